// ### shared/codec_ctrl_pkg.sv
// Constants, register map and lookup tables for the converter control block.
// Assumes the system clock is also the master audio clock.
package codec_ctrl_pkg;

	// Register page and word offsets
	localparam logic [3:0] CTRL_PAGE      = 4'h2;
	localparam logic [5:0] OFS_RATE_DIV   = 6'h00;
	localparam logic [5:0] OFS_AGC_CTRL   = 6'h01;
	localparam logic [5:0] OFS_STATUS     = 6'h04;
	localparam logic [5:0] OFS_CLK_NOISE  = 6'h06;
	localparam logic [5:0] OFS_PLL_INT    = 6'h1b;
	localparam logic [5:0] OFS_PLL_FRAC   = 6'h1c;
	localparam logic [5:0] OFS_STEP_HYST  = 6'h1d;
	localparam logic [5:0] OFS_LIMIT_DEB  = 6'h1e;

	// Field positions
	localparam int REC_DIV_LSB   = 0;
	localparam int PLAY_DIV_LSB  = 3;
	localparam int AGC_EN_BIT    = 0;
	localparam int TC_LSB        = 1;
	localparam int TGT_LSB       = 5;
	localparam int AGC_GAIN_LSB  = 8;
	localparam int ST_GAIN_EQ    = 0;
	localparam int ST_NOISE      = 11;
	localparam int ST_SAT        = 12;
	localparam int ST_REC_PD     = 13;
	localparam int CLIP_STEP_BIT = 3;
	localparam int NOISE_LSB     = 4;
	localparam int FSREF_SEL_BIT = 13;
	localparam int PLL_P_LSB     = 0;
	localparam int PLL_Q_LSB     = 4;
	localparam int PLL_J_LSB     = 8;
	localparam int PLL_EN_BIT    = 15;
	localparam int PLL_D_LSB     = 2;
	localparam int REQ_GAIN_LSB  = 0;
	localparam int PLAY_PWR_BIT  = 8;
	localparam int HYST_LSB      = 9;
	localparam int REC_PWR_BIT   = 11;
	localparam int SS_SLOW_BIT   = 12;
	localparam int SS_DIS_BIT    = 15;
	localparam int DEB_OUT_LSB   = 3;
	localparam int DEB_IN_LSB    = 6;
	localparam int MAXG_LSB      = 9;

	// Writable bits and reset values
	localparam logic [15:0] MASK_CLK_NOISE = 16'h2038;
	localparam logic [15:0] MASK_PLL_INT   = 16'hfff7;
	localparam logic [15:0] MASK_PLL_FRAC  = 16'hfffc;
	localparam logic [15:0] MASK_STEP_HYST = 16'h9f7f;
	localparam logic [15:0] MASK_LIMIT_DEB = 16'hfff8;
	localparam logic [15:0] RST_CFG        = 16'h0000;
	localparam logic [15:0] RST_LIMIT_DEB  = 16'hee00;

	// Clock generation and gain scales
	localparam int DIRECT_SCALE = 128;
	localparam int PLL_SCALE    = 2048;
	localparam int FRAC_SCALE   = 10000;
	localparam int Q_MIN        = 2;
	localparam logic [6:0] GAIN_MAX = 7'd119;
	localparam int SAMPLE_W     = 24;
	localparam logic [23:0] CLIP_LEVEL = 24'h7f0000;

	// Timing
	localparam int CLK_MHZ         = 100;
	localparam int ATTACK_MIN_MS   = 8;
	localparam int DECAY_MIN_MS    = 100;
	localparam int ATTACK_BASE_CYC = ATTACK_MIN_MS * CLK_MHZ * 1000;
	localparam int DECAY_BASE_CYC  = DECAY_MIN_MS * CLK_MHZ * 1000;

	// Record power sequence
	typedef enum logic [2:0] {
		PW_OFF  = 3'b001,
		PW_ON   = 3'b010,
		PW_DOWN = 3'b100
	} pwr_state_e;

	// Rate divider in half units: 1, 1.5, 2, 3, 4, 5, 5.5, 6
	function automatic logic [3:0] div_half(input logic [2:0] code);
		logic [3:0] v;
		v = 4'h2;
		case (code)
			3'h0: v = 4'h2;
			3'h1: v = 4'h3;
			3'h2: v = 4'h4;
			3'h3: v = 4'h6;
			3'h4: v = 4'h8;
			3'h5: v = 4'ha;
			3'h6: v = 4'hb;
			default: v = 4'hc;
		endcase
		return v;
	endfunction

	// Target average, -5.5 dB down to -24 dB of full scale
	function automatic logic [23:0] target_level(input logic [2:0] code);
		logic [23:0] v;
		v = 24'h0;
		case (code)
			3'h0: v = 24'h43f3d8;
			3'h1: v = 24'h32f551;
			3'h2: v = 24'h287a10;
			3'h3: v = 24'h2026f7;
			3'h4: v = 24'h198a1d;
			3'h5: v = 24'h12148a;
			3'h6: v = 24'h0ccccd;
			default: v = 24'h08138a;
		endcase
		return v;
	endfunction

	// Noise threshold -60, -70, -80, -90 dB and lowest allowed maximum gain
	function automatic logic [23:0] noise_level(input logic [1:0] code);
		return (code == 2'h0) ? 24'h0020c5 : (code == 2'h1) ? 24'h000a5d :
			(code == 2'h2) ? 24'h000347 : 24'h000109;
	endfunction

	function automatic logic [6:0] min_max_gain(input logic [1:0] code);
		return (code == 2'h0) ? 7'd0 : (code == 2'h1) ? 7'd23 :
			(code == 2'h2) ? 7'd43 : 7'd63;
	endfunction

	// Decay multiples of the shortest decay time: 100..500 ms
	function automatic int decay_mult(input logic [1:0] code);
		return (code == 2'h0) ? 1 : (code == 2'h1) ? 2 : (code == 2'h2) ? 4 : 5;
	endfunction

endpackage

// ### src/codec_converter_ctrl.sv
// Converter clocking, input gain stepping and automatic gain loop with registers.
// Assumes sys_clk_in is the master clock and the register port is same-clock.
// Overview of operation
// - Playback and record rates divide reference rate
// - Without PLL, reference is clock over 128Q
// - With PLL, reference is clock*K over 2048P
// - Gain 0-59.5 dB, half-dB step per samples
// - Mute at reset, ramp to mute before off
// - Status flag when applied equals requested gain
// - Disable bit makes gain changes immediate
// - Converter powered: external clocks, oscillator off
// - Amplitude is running mean of magnitude
// - Eight target levels from -5.5 to -24 dB
// - Programmable attack and decay time constants
// - Silence ramps gain to 0 dB, flags noise
// - Four noise thresholds, debounce and hysteresis
// - Hysteresis and debounce fields as mapped
// - Loop gain capped by programmable maximum
// - Loop fields placed in page two registers
`timescale 1ns/1ps
`default_nettype none
module codec_converter_ctrl #(
	parameter int ATTACK_BASE_CYC = codec_ctrl_pkg::ATTACK_BASE_CYC,
	parameter int DECAY_BASE_CYC  = codec_ctrl_pkg::DECAY_BASE_CYC
)(
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// Control register port
	input  wire logic [3:0]  reg_page_in,
	input  wire logic [5:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_wdata_in,
	output logic      [15:0] reg_rdata_out,
	output logic             reg_rvalid_out,
	// Record samples after the gain stage
	input  wire logic [23:0] rec_sample_in,
	input  wire logic        rec_sample_valid_in,
	// Rate strobes and clock selection
	output logic             fsref_tick_out,
	output logic             play_tick_out,
	output logic             rec_tick_out,
	output logic             fsref_sel_out,
	output logic             meas_ext_clk_out,
	output logic             osc_pd_out,
	// Input gain stage
	output logic      [6:0]  pga_gain_out,
	output logic             pga_mute_out,
	output logic             rec_power_out
);
	localparam int W = codec_ctrl_pkg::SAMPLE_W;

	logic [5:0]  div_reg, div_next;
	logic [7:0]  agc_reg, agc_next;
	logic [15:0] clkn_reg, clkn_next, plli_reg, plli_next, pllf_reg, pllf_next;
	logic [15:0] step_reg, step_next, lim_reg, lim_next, rdata_reg, rdata_next, st_word;
	logic        rvalid_reg, rvalid_next, page_hit;
	logic [6:0]  agc_gain_reg, agc_gain_next, eff_max, host_gain, max_field;
	logic [31:0] timer_reg, timer_next, attack_cyc, decay_cyc;
	logic [7:0]  appl_reg, appl_next, goal;
	logic        phase_reg, phase_next;
	codec_ctrl_pkg::pwr_state_e pwr_reg, pwr_next;
	logic [W-1:0] avg, tgt, thr, exit_thr;
	logic        silent, clip, rec_tick, agc_en, loud, quiet, step_now;
	logic [1:0]  thr_code, hyst_code;
	logic [1:0]  ticks;

	if (ATTACK_BASE_CYC < 1 || DECAY_BASE_CYC < 1) $error("time constant counts must be positive");

	// Reference and per-path rates
	rate_gen #(
		.CH(2)
	) u_rate (
		.sys_clk_in     (sys_clk_in),
		.rst_n_in       (rst_n_in),
		.pll_en_in      (plli_reg[codec_ctrl_pkg::PLL_EN_BIT]),
		.q_code_in      (plli_reg[codec_ctrl_pkg::PLL_Q_LSB +: 4]),
		.p_code_in      (plli_reg[codec_ctrl_pkg::PLL_P_LSB +: 3]),
		.j_in           (plli_reg[codec_ctrl_pkg::PLL_J_LSB +: 7]),
		.frac_in        (pllf_reg[codec_ctrl_pkg::PLL_D_LSB +: 14]),
		.div_code_in    ({div_reg[codec_ctrl_pkg::PLAY_DIV_LSB +: 3],
		                  div_reg[codec_ctrl_pkg::REC_DIV_LSB +: 3]}),
		.fsref_tick_out (fsref_tick_out),
		.rate_tick_out  (ticks)
	);

	assign rec_tick      = ticks[0];
	assign rec_tick_out  = ticks[0];
	assign play_tick_out = ticks[1];

	// Threshold and hysteresis levels for the silence detector
	always_comb
	begin
		thr_code  = clkn_reg[codec_ctrl_pkg::NOISE_LSB +: 2];
		hyst_code = step_reg[codec_ctrl_pkg::HYST_LSB +: 2];
		thr       = codec_ctrl_pkg::noise_level(thr_code);
		exit_thr  = thr + W'((thr * hyst_code) >> 3);
	end

	level_monitor #(
		.W     (W),
		.SHIFT (5)
	) u_level (
		.sys_clk_in      (sys_clk_in),
		.rst_n_in        (rst_n_in),
		.sample_in       (rec_sample_in),
		.valid_in        (rec_sample_valid_in),
		.enter_level_in  (thr),
		.exit_level_in   (exit_thr),
		.deb_in_code_in  (lim_reg[codec_ctrl_pkg::DEB_IN_LSB +: 3]),
		.deb_out_code_in (lim_reg[codec_ctrl_pkg::DEB_OUT_LSB +: 3]),
		.avg_out         (avg),
		.silent_out      (silent),
		.clip_out        (clip)
	);

	assign page_hit = (reg_page_in == codec_ctrl_pkg::CTRL_PAGE);

	// Configuration writes and registered read data
	always_comb
	begin
		div_next    = div_reg;
		agc_next    = agc_reg;
		clkn_next   = clkn_reg;
		plli_next   = plli_reg;
		pllf_next   = pllf_reg;
		step_next   = step_reg;
		lim_next    = lim_reg;
		rdata_next  = rdata_reg;
		rvalid_next = reg_rd_in;
		st_word     = 16'h0000;
		st_word[codec_ctrl_pkg::ST_GAIN_EQ] = (appl_reg == goal);
		st_word[codec_ctrl_pkg::ST_NOISE]   = agc_en && silent;
		st_word[codec_ctrl_pkg::ST_SAT]     = clip;
		st_word[codec_ctrl_pkg::ST_REC_PD]  = (pwr_reg == codec_ctrl_pkg::PW_OFF);
		if (reg_wr_in && page_hit)
		begin
			case (reg_addr_in)
				codec_ctrl_pkg::OFS_RATE_DIV:  div_next  = reg_wdata_in[5:0];
				codec_ctrl_pkg::OFS_AGC_CTRL:  agc_next  = reg_wdata_in[7:0];
				codec_ctrl_pkg::OFS_CLK_NOISE: clkn_next = reg_wdata_in & codec_ctrl_pkg::MASK_CLK_NOISE;
				codec_ctrl_pkg::OFS_PLL_INT:   plli_next = reg_wdata_in & codec_ctrl_pkg::MASK_PLL_INT;
				codec_ctrl_pkg::OFS_PLL_FRAC:  pllf_next = reg_wdata_in & codec_ctrl_pkg::MASK_PLL_FRAC;
				codec_ctrl_pkg::OFS_STEP_HYST: step_next = reg_wdata_in & codec_ctrl_pkg::MASK_STEP_HYST;
				codec_ctrl_pkg::OFS_LIMIT_DEB: lim_next  = reg_wdata_in & codec_ctrl_pkg::MASK_LIMIT_DEB;
				default: ;
			endcase
		end
		if (reg_rd_in)
		begin
			rdata_next = 16'h0000;
			if (page_hit)
			begin
				case (reg_addr_in)
					codec_ctrl_pkg::OFS_RATE_DIV:  rdata_next = {10'h000, div_reg};
					codec_ctrl_pkg::OFS_AGC_CTRL:  rdata_next = {1'b0, agc_gain_reg, agc_reg};
					codec_ctrl_pkg::OFS_STATUS:    rdata_next = st_word;
					codec_ctrl_pkg::OFS_CLK_NOISE: rdata_next = clkn_reg;
					codec_ctrl_pkg::OFS_PLL_INT:   rdata_next = plli_reg;
					codec_ctrl_pkg::OFS_PLL_FRAC:  rdata_next = pllf_reg;
					codec_ctrl_pkg::OFS_STEP_HYST: rdata_next = step_reg;
					codec_ctrl_pkg::OFS_LIMIT_DEB: rdata_next = lim_reg;
					default: rdata_next = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			div_reg    <= 6'h00;
			agc_reg    <= 8'h00;
			clkn_reg   <= codec_ctrl_pkg::RST_CFG;
			plli_reg   <= codec_ctrl_pkg::RST_CFG;
			pllf_reg   <= codec_ctrl_pkg::RST_CFG;
			step_reg   <= codec_ctrl_pkg::RST_CFG;
			lim_reg    <= codec_ctrl_pkg::RST_LIMIT_DEB;
			rdata_reg  <= 16'h0000;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			div_reg    <= div_next;
			agc_reg    <= agc_next;
			clkn_reg   <= clkn_next;
			plli_reg   <= plli_next;
			pllf_reg   <= pllf_next;
			step_reg   <= step_next;
			lim_reg    <= lim_next;
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign reg_rdata_out  = rdata_reg;
	assign reg_rvalid_out = rvalid_reg;
	assign fsref_sel_out  = clkn_reg[codec_ctrl_pkg::FSREF_SEL_BIT];

	// Automatic gain loop: silence ramp, clip step, attack and decay timers
	always_comb
	begin
		agc_en     = agc_reg[codec_ctrl_pkg::AGC_EN_BIT];
		host_gain  = step_reg[codec_ctrl_pkg::REQ_GAIN_LSB +: 7];
		if (host_gain > codec_ctrl_pkg::GAIN_MAX)
			host_gain = codec_ctrl_pkg::GAIN_MAX;
		max_field  = lim_reg[codec_ctrl_pkg::MAXG_LSB +: 7];
		eff_max    = (max_field < codec_ctrl_pkg::min_max_gain(thr_code)) ?
			codec_ctrl_pkg::min_max_gain(thr_code) : max_field;
		if (eff_max > codec_ctrl_pkg::GAIN_MAX)
			eff_max = codec_ctrl_pkg::GAIN_MAX;
		tgt        = codec_ctrl_pkg::target_level(agc_reg[codec_ctrl_pkg::TGT_LSB +: 3]);
		attack_cyc = 32'((ATTACK_BASE_CYC * (2 + int'(agc_reg[codec_ctrl_pkg::TC_LSB + 2 +: 2]))) / 2);
		decay_cyc  = 32'(DECAY_BASE_CYC * codec_ctrl_pkg::decay_mult(agc_reg[codec_ctrl_pkg::TC_LSB +: 2]));
		loud       = (avg > tgt);
		quiet      = (avg < tgt);
		agc_gain_next = agc_gain_reg;
		timer_next    = 32'h0;
		if (!agc_en)
			agc_gain_next = host_gain;
		else if (silent)
		begin
			if (rec_tick && agc_gain_reg != 7'd0)
				agc_gain_next = agc_gain_reg - 7'd1;
		end
		else if (clip && clkn_reg[codec_ctrl_pkg::CLIP_STEP_BIT] && rec_tick)
		begin
			if (agc_gain_reg != 7'd0)
				agc_gain_next = agc_gain_reg - 7'd1;
		end
		else if (loud || quiet)
		begin
			timer_next = timer_reg + 32'h1;
			if (loud && timer_next >= attack_cyc)
			begin
				timer_next = 32'h0;
				if (agc_gain_reg != 7'd0)
					agc_gain_next = agc_gain_reg - 7'd1;
			end
			else if (quiet && timer_next >= decay_cyc)
			begin
				timer_next = 32'h0;
				if (agc_gain_reg < eff_max)
					agc_gain_next = agc_gain_reg + 7'd1;
			end
		end
		if (agc_en && agc_gain_next > eff_max)
			agc_gain_next = eff_max;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			agc_gain_reg <= 7'd0;
			timer_reg    <= 32'h0;
		end
		else
		begin
			agc_gain_reg <= agc_gain_next;
			timer_reg    <= timer_next;
		end
	end

	// Record power sequence and soft-stepped applied gain level
	always_comb
	begin
		pwr_next   = pwr_reg;
		phase_next = phase_reg;
		appl_next  = appl_reg;
		step_now   = 1'b0;
		unique case (pwr_reg)
			codec_ctrl_pkg::PW_OFF:
				if (step_reg[codec_ctrl_pkg::REC_PWR_BIT])
					pwr_next = codec_ctrl_pkg::PW_ON;
			codec_ctrl_pkg::PW_ON:
				if (!step_reg[codec_ctrl_pkg::REC_PWR_BIT])
					pwr_next = codec_ctrl_pkg::PW_DOWN;
			codec_ctrl_pkg::PW_DOWN:
				if (step_reg[codec_ctrl_pkg::REC_PWR_BIT])
					pwr_next = codec_ctrl_pkg::PW_ON;
				else if (appl_reg == 8'h00)
					pwr_next = codec_ctrl_pkg::PW_OFF;
		endcase
		// Level 0 is mute, level n is gain n-1 half-decibels
		goal = (pwr_reg == codec_ctrl_pkg::PW_ON) ?
			{1'b0, (agc_en ? agc_gain_reg : host_gain)} + 8'h01 : 8'h00;
		if (rec_tick)
		begin
			phase_next = !phase_reg;
			step_now   = !step_reg[codec_ctrl_pkg::SS_SLOW_BIT] || phase_reg;
		end
		if (pwr_reg == codec_ctrl_pkg::PW_OFF)
			appl_next = 8'h00;
		else if (step_reg[codec_ctrl_pkg::SS_DIS_BIT])
			appl_next = goal;
		else if (step_now && appl_reg < goal)
			appl_next = appl_reg + 8'h01;
		else if (step_now && appl_reg > goal)
			appl_next = appl_reg - 8'h01;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pwr_reg   <= codec_ctrl_pkg::PW_OFF;
			phase_reg <= 1'b0;
			appl_reg  <= 8'h00;
		end
		else
		begin
			pwr_reg   <= pwr_next;
			phase_reg <= phase_next;
			appl_reg  <= appl_next;
		end
	end

	// Gain stage and clock source outputs
	assign pga_mute_out     = (appl_reg == 8'h00);
	assign pga_gain_out     = pga_mute_out ? 7'd0 : 7'(appl_reg - 8'h01);
	assign rec_power_out    = (pwr_reg != codec_ctrl_pkg::PW_OFF);
	assign meas_ext_clk_out = rec_power_out || step_reg[codec_ctrl_pkg::PLAY_PWR_BIT];
	assign osc_pd_out       = rec_power_out || step_reg[codec_ctrl_pkg::PLAY_PWR_BIT];
endmodule
`default_nettype wire

// ### src/level_monitor.sv
// Absolute-average level tracker with debounced silence detection.
// Assumes record samples arrive as same-clock two's complement words.
`timescale 1ns/1ps
`default_nettype none
module level_monitor #(
	parameter int W     = 24,
	parameter int SHIFT = 5
)(
	// Clock and reset
	input  wire logic          sys_clk_in,
	input  wire logic          rst_n_in,
	// Record samples
	input  wire logic [W-1:0]  sample_in,
	input  wire logic          valid_in,
	// Thresholds and debounce codes
	input  wire logic [W-1:0]  enter_level_in,
	input  wire logic [W-1:0]  exit_level_in,
	input  wire logic [2:0]    deb_in_code_in,
	input  wire logic [2:0]    deb_out_code_in,
	// Results
	output logic [W-1:0]       avg_out,
	output logic               silent_out,
	output logic               clip_out
);
	logic [W-1:0] mag, avg_reg, avg_next;
	logic [W:0]   avg_sum;
	logic [7:0]   cnt_reg, cnt_next, lim;
	logic         silent_reg, silent_next, clip_reg, clip_next;

	if (W < 16 || SHIFT < 1 || SHIFT >= W) $error("level_monitor width or shift unusable");

	// Running mean of magnitude, then silence entry and exit with debounce
	always_comb
	begin
		mag         = sample_in[W-1] ? (~sample_in + 1'b1) : sample_in;
		avg_sum     = {1'b0, avg_reg} + (W+1)'(mag >> SHIFT) - (W+1)'(avg_reg >> SHIFT);
		avg_next    = avg_reg;
		cnt_next    = cnt_reg;
		silent_next = silent_reg;
		clip_next   = clip_reg;
		lim         = 8'h01 << (silent_reg ? deb_out_code_in : deb_in_code_in);
		if (valid_in)
		begin
			avg_next  = avg_sum[W-1:0];
			clip_next = (mag >= W'(codec_ctrl_pkg::CLIP_LEVEL));
			if ((!silent_reg && avg_reg < enter_level_in) || (silent_reg && avg_reg > exit_level_in))
			begin
				if (cnt_reg + 8'h01 >= lim)
				begin
					silent_next = !silent_reg;
					cnt_next    = 8'h00;
				end
				else
					cnt_next = cnt_reg + 8'h01;
			end
			else
				cnt_next = 8'h00;
		end
	end

	// Monitor state
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			avg_reg    <= '0;
			cnt_reg    <= 8'h00;
			silent_reg <= 1'b0;
			clip_reg   <= 1'b0;
		end
		else
		begin
			avg_reg    <= avg_next;
			cnt_reg    <= cnt_next;
			silent_reg <= silent_next;
			clip_reg   <= clip_next;
		end
	end

	assign avg_out    = avg_reg;
	assign silent_out = silent_reg;
	assign clip_out   = clip_reg;
endmodule
`default_nettype wire

// ### src/rate_gen.sv
// Reference rate generator and per-channel half-step rate dividers.
// Assumes the system clock is the master clock; all inputs are same-clock.
`timescale 1ns/1ps
`default_nettype none
module rate_gen #(
	parameter int CH = 2
)(
	// Clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	// Clock configuration
	input  wire logic              pll_en_in,
	input  wire logic [3:0]        q_code_in,
	input  wire logic [2:0]        p_code_in,
	input  wire logic [6:0]        j_in,
	input  wire logic [13:0]       frac_in,
	input  wire logic [CH*3-1:0]   div_code_in,
	// Rate strobes
	output logic                   fsref_tick_out,
	output logic [CH-1:0]          rate_tick_out
);
	logic [11:0] cnt_reg, cnt_next, dir_limit;
	logic [27:0] acc_reg, acc_next, pll_mod;
	logic [19:0] pll_inc;
	logic [28:0] acc_sum;
	logic        tick_reg, tick_next;

	if (CH < 1) $error("rate_gen needs at least one channel");

	// Direct divide by 128*Q, or fractional accumulator for MCLK*K/(2048*P)
	always_comb
	begin
		dir_limit = 12'(codec_ctrl_pkg::DIRECT_SCALE * (int'(q_code_in) + codec_ctrl_pkg::Q_MIN) - 1);
		pll_inc   = 20'(int'(j_in) * codec_ctrl_pkg::FRAC_SCALE + int'(frac_in));
		pll_mod   = 28'(codec_ctrl_pkg::PLL_SCALE * codec_ctrl_pkg::FRAC_SCALE * (int'(p_code_in) + 1));
		acc_sum   = 29'(acc_reg) + 29'(pll_inc);
		cnt_next  = cnt_reg;
		acc_next  = acc_reg;
		tick_next = 1'b0;
		if (pll_en_in)
		begin
			cnt_next = 12'h000;
			if (acc_sum >= 29'(pll_mod))
			begin
				acc_next  = 28'(acc_sum - 29'(pll_mod));
				tick_next = 1'b1;
			end
			else
				acc_next = acc_sum[27:0];
		end
		else
		begin
			acc_next = 28'h0;
			if (cnt_reg >= dir_limit)
			begin
				cnt_next  = 12'h000;
				tick_next = 1'b1;
			end
			else
				cnt_next = cnt_reg + 12'h001;
		end
	end

	// Reference rate state
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_reg  <= 12'h000;
			acc_reg  <= 28'h0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			acc_reg  <= acc_next;
			tick_reg <= tick_next;
		end
	end

	assign fsref_tick_out = tick_reg;

	// One divider per channel, counting two half units per reference tick
	for (genvar g = 0; g < CH; g++)
	begin : g_div
		logic [4:0] hacc_reg, hacc_next, hsum, lim;
		logic       out_reg, out_next;

		always_comb
		begin
			lim       = {1'b0, codec_ctrl_pkg::div_half(div_code_in[3*g +: 3])};
			hsum      = hacc_reg + 5'h02;
			hacc_next = hacc_reg;
			out_next  = 1'b0;
			if (tick_reg)
			begin
				if (hsum >= lim)
				begin
					hacc_next = hsum - lim;
					out_next  = 1'b1;
				end
				else
					hacc_next = hsum;
			end
		end

		always_ff @(posedge sys_clk_in or negedge rst_n_in)
		begin
			if (!rst_n_in)
			begin
				hacc_reg <= 5'h00;
				out_reg  <= 1'b0;
			end
			else
			begin
				hacc_reg <= hacc_next;
				out_reg  <= out_next;
			end
		end

		assign rate_tick_out[g] = out_reg;
	end
endmodule
`default_nettype wire

// ### verification/codec_converter_ctrl_bench.sv
// Self-checking bench for the converter control block.
// Assumes the host model and port checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module codec_converter_ctrl_bench;
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [3:0]  reg_page_in, q;
	logic [5:0]  reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out;
	logic        reg_wr_in, reg_rd_in, reg_rvalid_out, rec_sample_valid_in = 1'b0;
	logic [23:0] rec_sample_in = 24'h0;
	logic        fsref_tick_out, play_tick_out, rec_tick_out, fsref_sel_out;
	logic        meas_ext_clk_out, osc_pd_out, pga_mute_out, rec_power_out;
	logic [6:0]  pga_gain_out, g;
	logic [16:0] r;
	int          mismatches = 0, cmp_count = 0, c, n, m, t;
	// Clock
	always #5 sys_clk_in = ~sys_clk_in;
	codec_converter_ctrl #(.ATTACK_BASE_CYC(20), .DECAY_BASE_CYC(100)) dut (.sys_clk_in,
		.rst_n_in, .reg_page_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
		.reg_rdata_out, .reg_rvalid_out, .rec_sample_in, .rec_sample_valid_in,
		.fsref_tick_out, .play_tick_out, .rec_tick_out, .fsref_sel_out,
		.meas_ext_clk_out, .osc_pd_out, .pga_gain_out, .pga_mute_out, .rec_power_out);
	host_model hm (.clk_in(sys_clk_in), .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out),
		.page_out(reg_page_in), .addr_out(reg_addr_in), .wr_out(reg_wr_in),
		.rd_out(reg_rd_in), .wdata_out(reg_wdata_in));
	// Small random record samples
	always @(negedge sys_clk_in)
	begin
		rec_sample_in <= 24'($urandom % 65536);
		rec_sample_valid_in <= ($urandom % 4) == 0;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [5:0] a, input logic [15:0] d);
		hm.xfer(1'b1, {4'h2, a}, d, r);
	endtask
	task automatic get(input logic [5:0] a);
		hm.xfer(1'b0, {4'h2, a}, 16'h0, r);
	endtask
	// Divider in half units
	function automatic int hv(input int k);
		return k < 3 ? k + 2 : k < 6 ? 2 * k : k + 5;
	endfunction
	function automatic logic pick(input int s);
		return s == 0 ? fsref_tick_out : s == 1 ? play_tick_out : s == 2 ? rec_tick_out :
			s == 3 ? pga_gain_out === g : rec_power_out === 1'b0;
	endfunction
	// Cycles until the selected event
	task automatic span(input int s, output int k);
		k = 0;
		do
		begin
			@(negedge sys_clk_in);
			k++;
		end
		while (!pick(s) && k < 9000);
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#900000;
		mismatches++;
		give_verdict;
	end
	// Main sequence
	initial
	begin
		void'($urandom(7550));
		repeat (10) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		get(6'h04);
		chk(r[15:0], 16'h2001);
		hm.xfer(1'b1, {4'h1, 6'h1e}, 16'h1234, r);
		get(6'h1e);
		chk(r[15:0], 16'hee00);
		get(6'h10);
		chk(r[16:1], 16'h8000);
		put(6'h06, 16'hffff);
		get(6'h06);
		chk(r[15:0], 16'h2038);
		chk({15'h0, fsref_sel_out}, 16'h1);
		q = 4'($urandom % 3);
		t = 128 * (q + 2);
		put(6'h1b, {8'h00, q, 4'h0});
		span(0, n);
		span(0, n);
		chk(16'(n), 16'(t));
		for (c = 0; c < 8; c++)
		begin
			put(6'h00, {10'h0, c[2:0], 3'h0});
			span(1, n);
			span(1, n);
			span(1, m);
			chk(16'(n + m), 16'(hv(c) * t));
		end
		span(2, n);
		span(2, n);
		chk(16'(n), 16'(t));
		g = 7'($urandom % 8 + 3);
		put(6'h1d, {9'h010, g});
		get(6'h04);
		chk({r[13], r[0]}, 16'h0);
		span(3, n);
		chk(16'(n > (g - 2) * t && n <= (g + 1) * t), 16'h1);
		get(6'h04);
		chk({r[0], pga_mute_out}, 16'h2);
		g = 7'($urandom % 8 + 3);
		put(6'h1d, {9'h110, g});
		repeat (3) @(negedge sys_clk_in);
		chk({9'h0, pga_gain_out}, {9'h0, g});
		put(6'h1d, {9'h000, g});
		chk({15'h0, rec_power_out}, 16'h1);
		span(4, n);
		chk(16'(n > (g - 2) * t), 16'h1);
		get(6'h04);
		chk({r[13], pga_mute_out}, 16'h3);
		put(6'h1d, 16'h0100);
		chk({meas_ext_clk_out, osc_pd_out}, 16'h3);
		put(6'h1b, 16'h8504);
		span(0, n);
		span(0, n);
		chk(16'(n), 16'h0800);
		put(6'h1c, 16'h3e80);
		put(6'h1b, 16'h8607);
		span(0, n);
		span(0, n);
		chk(16'(n), 16'h0a00);
		g = 7'($urandom % 8 + 64);
		put(6'h1e, {g, 9'h000});
		put(6'h01, 16'h0001);
		repeat (8000) @(negedge sys_clk_in);
		get(6'h01);
		chk(r[15:0], {1'b0, g, 8'h01});
		give_verdict;
	end
endmodule
`default_nettype wire

// ### verification/codec_ctrl_chk.sv
// Port checker for the converter control block.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_chk (
	// Watched ports
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	input wire logic       reg_rd_in,
	input wire logic       reg_rvalid_out,
	input wire logic       fsref_tick_out,
	input wire logic       play_tick_out,
	input wire logic       rec_tick_out,
	input wire logic       meas_ext_clk_out,
	input wire logic       osc_pd_out,
	input wire logic [6:0] pga_gain_out,
	input wire logic       pga_mute_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Read answer timing
	read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("no read answer");
	read_pulse_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
		else $error("stray read answer");
	// Rate strobes follow the reference
	rec_tick_a: assert property (rec_tick_out |-> $past(fsref_tick_out))
		else $error("record tick unaligned");
	play_tick_a: assert property (play_tick_out |-> $past(fsref_tick_out))
		else $error("playback tick unaligned");
	ref_gap_a: assert property (fsref_tick_out |=> !fsref_tick_out [*8])
		else $error("reference ticks too close");
	// Clock source and gain stage
	clk_source_a: assert property (meas_ext_clk_out == osc_pd_out)
		else $error("clock source mismatch");
	gain_range_a: assert property (pga_gain_out <= 7'h77)
		else $error("gain above range");
	mute_zero_a: assert property (pga_mute_out |-> pga_gain_out == 7'h0)
		else $error("gain while muted");
endmodule
bind codec_converter_ctrl codec_ctrl_chk chk (.sys_clk_in, .rst_n_in, .reg_rd_in,
	.reg_rvalid_out, .fsref_tick_out, .play_tick_out, .rec_tick_out,
	.meas_ext_clk_out, .osc_pd_out, .pga_gain_out, .pga_mute_out);
`default_nettype wire

// ### verification/host_model.sv
// Host model driving the paged register port.
// Assumes the block clock; requests launch at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock and register port
	input  wire logic        clk_in,
	input  wire logic [15:0] rdata_in,
	input  wire logic        rvalid_in,
	output logic      [3:0]  page_out,
	output logic      [5:0]  addr_out,
	output logic             wr_out,
	output logic             rd_out,
	output logic      [15:0] wdata_out
);
	// Idle bus at time zero
	initial
	begin
		{page_out, addr_out, wr_out, rd_out, wdata_out} = '0;
	end
	// One access, answer taken as the strobe drops
	task automatic xfer(input logic w, input logic [9:0] pa, input logic [15:0] d,
		output logic [16:0] r);
		@(negedge clk_in);
		{page_out, addr_out} = pa;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(negedge clk_in);
		{wr_out, rd_out} = 2'b00;
		wdata_out = ~d;
		r = {rvalid_in, rdata_in};
	endtask
endmodule
`default_nettype wire
